// *** inc/adc_audio_consts.vh ***
// Purpose: constants for the adc audio serial port
// Assumes: classic wishbone, byte address = 4 x register index
// Notes: included by the port and by its clock scaler
//
// Notes on behaviour
// - left-justified: msb on first rising bit clock after frame edge, spare slots trail.
// - right-justified: lsb on last rising bit clock before frame edge, spares lead.
// - i2s: msb on second rising bit clock after frame edge, then bits in order.
// - dsp mode a: left msb on 2nd rising edge after frame rise, right follows.
// - dsp with phase swap: data starts one word length after left slot.
// - phase swap bit 1, reset 0: 0 puts data left, 1 right.
// - format bits 4:3, reset 10: right, left, i2s, dsp.
// - word length bits 6:5, reset 10: 16, 20, 24, 32 bits.
// - master select bit 0, reset 0: 1 drives both clocks out.
// - bit clock divider bits 4:2 divide by 1..32; frame from same chain.
// - non-integer bit clocks per frame may give a short last pulse.
// - scaler bits 7:5, reset 010: divide by 1,1.5,2,3,4,6,8,12.
// - source select bit 8, reset 1: 0 external clock pin, 1 pll.
// - slave mode returns data timed by the received clocks.
`ifndef ADC_AUDIO_CONSTS_VH
`define ADC_AUDIO_CONSTS_VH

`define AIF_INDEX        8'h04
`define CLKGEN_INDEX     8'h06
`define STATUS_INDEX     8'h07
`define AIF_ADDR         8'h10
`define CLKGEN_ADDR      8'h18
`define STATUS_ADDR      8'h1C

`define AIF_RESET        9'h050
`define CLKGEN_RESET     9'h140

`define AIF_SWAP_BIT     1
`define AIF_FMT_LO       3
`define AIF_WL_LO        5
`define AIF_FRAME_POLARITY_BIT   7
`define AIF_BCP_BIT      8
`define CLK_MS_BIT       0
`define CLK_BDIV_LO      2
`define CLK_SCALE_LO     5
`define CLK_SEL_BIT      8

`define FMT_RIGHT        2'h0
`define FMT_LEFT         2'h1
`define FMT_I2S          2'h2
`define FMT_DSP          2'h3

`define WL_BITS_16       6'h10
`define WL_BITS_20       6'h14
`define WL_BITS_24       6'h18
`define WL_BITS_32       6'h20

// scaler thresholds in source half periods x2
`define SCALE_T0         6'h02
`define SCALE_T1         6'h03
`define SCALE_T2         6'h04
`define SCALE_T3         6'h06
`define SCALE_T4         6'h08
`define SCALE_T5         6'h0C
`define SCALE_T6         6'h10
`define SCALE_T7         6'h18

`endif

// *** design/clk_scaler.v ***
// Purpose: divides the selected clock source into internal half-period ticks
// Assumes: source input synchronous to sys_clk_i, well below half its rate
// Notes: fractional ratio 1.5 is done by accumulation, so tick spacing jitters
`timescale 1ns/1ns
`include "adc_audio_consts.vh"

module clk_scaler (
	input  wire       sys_clk_i,
	input  wire       rst_i,
	input  wire       src_i,
	input  wire [2:0] scale_i,
	output reg        tick_o
);
	reg        src_q;
	reg  [5:0] acc;
	reg  [5:0] thr;
	wire       src_edge = src_i ^ src_q;
	wire [5:0] acc_add  = acc + 6'h02;

	always @* begin
		case (scale_i)
		3'h0:    thr = `SCALE_T0;
		3'h1:    thr = `SCALE_T1;
		3'h2:    thr = `SCALE_T2;
		3'h3:    thr = `SCALE_T3;
		3'h4:    thr = `SCALE_T4;
		3'h5:    thr = `SCALE_T5;
		3'h6:    thr = `SCALE_T6;
		default: thr = `SCALE_T7;
		endcase
	end

	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			src_q  <= 1'b0;
			acc    <= 6'h00;
			tick_o <= 1'b0;
		end else begin
			src_q  <= src_i;
			tick_o <= 1'b0;
			if (src_edge) begin
				// each source edge is worth two units, one tick per threshold
				if (acc_add >= thr) begin
					acc    <= acc_add - thr;
					tick_o <= 1'b1;
				end else begin
					acc <= acc_add;
				end
			end
		end
	end
endmodule // clk_scaler

// *** design/adc_audio_serial_port.v ***
// Purpose: serial audio output port of a mono adc, with register file
// Assumes: all pins synchronous to sys_clk_i; clock pins far below its rate
// Notes: data changes after falling bit clock, so the far end samples on rising
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ns
`include "adc_audio_consts.vh"

module adc_audio_serial_port #(
	parameter [9:0] MCLK_PER_FRAME = 10'd256
) (
	input  wire        sys_clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        mclk_pin_i,
	input  wire        pll_clk_i,
	input  wire [31:0] sample_i,
	output reg         sample_take_o,
	input  wire        bitclk_i,
	output wire        bitclk_o,
	output wire        bitclk_oe_o,
	input  wire        frame_output_i,
	output wire        frame_output_o,
	output wire        frame_output_oe_o,
	output reg         sample_data_out_o
);
	// register file
	reg  [8:0]  aif;
	reg  [8:0]  clkgen;
	wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	wire        phase_swap         = aif[`AIF_SWAP_BIT];
	wire [1:0]  format_select      = aif[`AIF_FMT_LO+1:`AIF_FMT_LO];
	wire [1:0]  word_length_select = aif[`AIF_WL_LO+1:`AIF_WL_LO];
	wire        frame_polarity     = aif[`AIF_FRAME_POLARITY_BIT];
	wire        bitclk_polarity    = aif[`AIF_BCP_BIT];
	wire        master_select      = clkgen[`CLK_MS_BIT];
	wire [2:0]  bitclk_divider     = clkgen[`CLK_BDIV_LO+2:`CLK_BDIV_LO];
	wire [2:0]  sysclk_scaler      = clkgen[`CLK_SCALE_LO+2:`CLK_SCALE_LO];
	wire        clock_source_select = clkgen[`CLK_SEL_BIT];

	wire        is_dsp = (format_select == `FMT_DSP);

	// status fields
	reg  [9:0]  slot_cnt;
	reg  [9:0]  half_len;
	wire        frame_int;
	wire        bclk_int;
	wire        left_phase;

	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			aif      <= `AIF_RESET;
			clkgen   <= `CLKGEN_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req & wb_we_i) begin
				if (wb_adr_i == `AIF_ADDR) begin
					if (wb_sel_i[0])
						aif[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1])
						aif[8] <= wb_dat_i[8];
				end
				if (wb_adr_i == `CLKGEN_ADDR) begin
					if (wb_sel_i[0])
						clkgen[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1])
						clkgen[8] <= wb_dat_i[8];
				end
			end
			if (wb_req & ~wb_we_i) begin
				case (wb_adr_i)
				`AIF_ADDR:    wb_dat_o <= {23'h00_0000, aif};
				`CLKGEN_ADDR: wb_dat_o <= {23'h00_0000, clkgen};
				`STATUS_ADDR: wb_dat_o <= {9'h000, half_len, bclk_int, left_phase, frame_int, slot_cnt};
				default:      wb_dat_o <= 32'h0000_0000;
				endcase
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end

	// clock source and scaling
	wire        src_clk = clock_source_select ? pll_clk_i : mclk_pin_i;
	wire        half_tick;

	clk_scaler u_scaler (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.src_i     (src_clk),
		.scale_i   (sysclk_scaler),
		.tick_o    (half_tick)
	);

	// master clock generation; ticks are internal clock half periods
	reg  [10:0] frame_tick;
	reg  [5:0]  bdiv_cnt;
	reg         bclk_gen;
	reg  [5:0]  bdiv_last;
	wire [10:0] frame_last = {MCLK_PER_FRAME, 1'b0} - 11'h001;
	wire [10:0] dsp_pulse  = {4'h0, bdiv_last, 1'b0} + 11'h002;
	wire        first_half = (frame_tick < {1'b0, MCLK_PER_FRAME});
	reg         frame_gen;

	always @* begin
		// reserved divider codes hold the slowest rate
		case (bitclk_divider)
		3'h0:    bdiv_last = 6'h00;
		3'h1:    bdiv_last = 6'h01;
		3'h2:    bdiv_last = 6'h03;
		3'h3:    bdiv_last = 6'h07;
		3'h4:    bdiv_last = 6'h0F;
		default: bdiv_last = 6'h1F;
		endcase
	end

	always @* begin
		if (is_dsp)
			frame_gen = (frame_tick < dsp_pulse);
		else if (format_select == `FMT_I2S)
			frame_gen = ~first_half;
		else
			frame_gen = first_half;
	end

	always @(posedge sys_clk_i) begin
		if (rst_i | ~master_select) begin
			frame_tick <= 11'h000;
			bdiv_cnt   <= 6'h00;
			bclk_gen   <= 1'b0;
		end else if (half_tick) begin
			if (frame_tick == frame_last) begin
				// restart cuts any unfinished bit clock short
				frame_tick <= 11'h000;
				bdiv_cnt   <= 6'h00;
				bclk_gen   <= 1'b0;
			end else begin
				frame_tick <= frame_tick + 11'h001;
				if (bdiv_cnt >= bdiv_last) begin
					bdiv_cnt <= 6'h00;
					bclk_gen <= ~bclk_gen;
				end else begin
					bdiv_cnt <= bdiv_cnt + 6'h01;
				end
			end
		end
	end

	// pins; slave takes the far end's clocks
	assign bclk_int  = master_select ? bclk_gen : (bitclk_i ^ bitclk_polarity);
	assign frame_int = master_select ? frame_gen
		: (frame_output_i ^ (frame_polarity & ~is_dsp));
	assign bitclk_o          = bclk_gen ^ bitclk_polarity;
	assign bitclk_oe_o       = master_select;
	assign frame_output_o    = frame_gen ^ (frame_polarity & ~is_dsp);
	assign frame_output_oe_o = master_select;

	// frame level: left phase high, except i2s where left is low
	assign left_phase = (format_select == `FMT_I2S) ? ~frame_int : frame_int;

	// bit slot tracking
	reg         bclk_q;
	reg         frame_last_rise;
	wire        bclk_rise = bclk_int & ~bclk_q;
	wire        bclk_fall = ~bclk_int & bclk_q;
	// dsp frames start only on the pulse's rising edge; its width is ignored here
	wire        trans = is_dsp ? (frame_int & ~frame_last_rise)
		: (frame_int ^ frame_last_rise);

	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			bclk_q          <= 1'b0;
			frame_last_rise <= 1'b0;
			slot_cnt        <= 10'h000;
			half_len        <= 10'h000;
		end else begin
			bclk_q <= bclk_int;
			if (bclk_rise) begin
				frame_last_rise <= frame_int;
				if (trans) begin
					slot_cnt <= 10'h001;
					half_len <= slot_cnt;
				end else if (slot_cnt != 10'h3FF) begin
					slot_cnt <= slot_cnt + 10'h001;
				end
			end
		end
	end

	// word length in slots
	reg  [5:0]  wl;
	always @* begin
		case (word_length_select)
		2'h0:    wl = `WL_BITS_16;
		2'h1:    wl = `WL_BITS_20;
		2'h2:    wl = `WL_BITS_24;
		default: wl = `WL_BITS_32;
		endcase
	end

	// slot number of the coming rising edge
	wire [11:0] s   = trans ? 12'h001 : ({2'h0, slot_cnt} + 12'h001);
	wire [11:0] w   = {6'h00, wl};
	wire [11:0] hl  = {2'h0, half_len};
	wire        want_left = ~phase_swap;
	reg         bit_valid;
	reg  [11:0] pos;

	always @* begin
		bit_valid = 1'b0;
		pos       = 12'h000;
		case (format_select)
		`FMT_LEFT: begin
			pos       = s - 12'h001;
			bit_valid = (left_phase == want_left) && (s <= w);
		end
		`FMT_I2S: begin
			pos       = s - 12'h002;
			bit_valid = (left_phase == want_left) && (s >= 12'h002) && (s <= w + 12'h001);
		end
		`FMT_RIGHT: begin
			// length of the previous half frame predicts where the lsb lands
			pos       = s + w - 12'h001 - hl;
			bit_valid = (left_phase == want_left) && (s + w > hl) && (s <= hl);
		end
		`FMT_DSP: begin
			if (phase_swap) begin
				pos       = s - 12'h002 - w;
				bit_valid = (s >= w + 12'h002) && (s <= {w[10:0], 1'b0} + 12'h001);
			end else begin
				pos       = s - 12'h002;
				bit_valid = (s >= 12'h002) && (s <= w + 12'h001);
			end
		end
		default: begin
			pos       = 12'h000;
			bit_valid = 1'b0;
		end
		endcase
	end

	// a frame with data starts at a transition into the left phase
	wire        frame_start = trans & (is_dsp | left_phase);
	reg  [31:0] shift_word;
	wire [4:0]  bit_sel = 5'h1F - pos[4:0];

	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			shift_word        <= 32'h0000_0000;
			sample_take_o     <= 1'b0;
			sample_data_out_o <= 1'b0;
		end else begin
			sample_take_o <= 1'b0;
			if (bclk_fall) begin
				if (frame_start) begin
					shift_word    <= sample_i;
					sample_take_o <= 1'b1;
				end
				// msb first; a fresh word is used from its first slot
				if (bit_valid)
					sample_data_out_o <= frame_start ? sample_i[bit_sel] : shift_word[bit_sel];
				else
					sample_data_out_o <= 1'b0;
			end
		end
	end
endmodule // adc_audio_serial_port

// *** dv/port_monitor.sv ***
// Purpose: bus and link checks on the port pins
// Assumes: slave tests keep bitclk polarity normal
// Notes: bound from tb_top
`timescale 1ns/1ns
module port_monitor (
	input logic        sys_clk_i,
	input logic        rst_i,
	input logic        wb_cyc_i,
	input logic        wb_stb_i,
	input logic        wb_ack_o,
	input logic [31:0] wb_dat_o,
	input logic        bitclk_i,
	input logic        bitclk_o,
	input logic        bitclk_oe_o,
	input logic        frame_output_oe_o,
	input logic        sample_take_o,
	input logic        sample_data_out_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	chk_ack_answer: assert property (s_req |=> s_ans) else $error("ack timing");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i) && !$past(wb_ack_o))
		else $error("ack without request");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("dat not zero");
	chk_dat_width: assert property (wb_ack_o |-> wb_dat_o[31:23] == 9'h000) else $error("high bits set");
	chk_oe_pair: assert property (bitclk_oe_o == frame_output_oe_o) else $error("oe split");
	chk_data_low: assert property (!bitclk_oe_o && $changed(sample_data_out_o) |-> !$past(bitclk_i))
		else $error("data moved in high bclk");
	chk_take_low: assert property (sample_take_o && !bitclk_oe_o |-> !$past(bitclk_i))
		else $error("take off edge");
	chk_take_pulse: assert property (sample_take_o |=> !sample_take_o) else $error("take too long");
	chk_bclk_width: assert property (bitclk_oe_o && $rose(bitclk_o) |=> bitclk_o [*3])
		else $error("bclk pulse short");
endmodule // port_monitor

// *** dv/host_port_model.sv ***
// Purpose: host serial port, clocks the link as master
// Assumes: 64 bit clocks per frame, data sampled on rising bclk
// Notes: clock stands still while run_i is low
`timescale 1ns/1ns
module host_port_model #(
	parameter int HALF = 4
) (
	input  logic        sys_clk_i,
	input  logic        run_i,
	input  logic        dsp_i,
	input  logic        data_i,
	output logic        bclk_o,
	output logic        frame_o,
	output logic        done_o,
	output logic [64:1] cap_o
);
	int ph;
	int slot;
	initial begin
		bclk_o = 0;
		frame_o = 0;
		done_o = 0;
		cap_o = '0;
		ph = 0;
		slot = 0;
	end
	always @(posedge sys_clk_i) begin
		done_o <= 1'b0;
		if (run_i) begin
			ph <= (ph == HALF - 1) ? 0 : ph + 1;
			if (ph == HALF - 1) begin
				bclk_o <= !bclk_o;
				if (!bclk_o) begin
					slot <= slot + 1;
					cap_o[slot + 1] <= data_i;
				end else if (slot == 64) begin
					// frame edges only with falling bclk
					slot <= 0;
					frame_o <= 1'b1;
					done_o <= 1'b1;
				end else if (slot == (dsp_i ? 1 : 32))
					frame_o <= 1'b0;
			end
		end
	end
endmodule // host_port_model

// *** dv/tb_top.sv ***
// Purpose: self-checking bench for the serial port
// Assumes: short frame parameter, slave then master
// Notes: slot numbers count rising bclk from frame rise
`timescale 1ns/1ns
module tb_top;
	typedef struct {logic [8:0] r; int wl; int s;} row_t;
	logic        sys_clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, mclk_pin_i, pll_clk_i, run, dsp;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, sample_i, q;
	logic [63:0] e;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, sample_take_o, bitclk_o, bitclk_oe_o, done;
	wire         frame_output_o, frame_output_oe_o, sample_data_out_o, h_bclk, h_frame;
	wire  [64:1] cap;
	int          err_count, total_checks, n;
	row_t        rows[7] = '{'{9'h008, 16, 1}, '{9'h050, 24, 34}, '{9'h020, 20, 13}, '{9'h078, 32, 2},
		'{9'h01A, 16, 18}, '{9'h088, 16, 33}, '{9'h04A, 24, 33}};
	row_t        mrow[5] = '{'{9'h101, 0, 4}, '{9'h105, 0, 8}, '{9'h141, 0, 8}, '{9'h001, 0, 6},
		'{9'h061, 0, 18}};
	wire         bclk_w = bitclk_oe_o ? bitclk_o : h_bclk;
	wire         frame_w = frame_output_oe_o ? frame_output_o : h_frame;
	adc_audio_serial_port #(.MCLK_PER_FRAME(10'd32)) dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mclk_pin_i(mclk_pin_i),
		.pll_clk_i(pll_clk_i), .sample_i(sample_i), .sample_take_o(sample_take_o), .bitclk_i(bclk_w),
		.bitclk_o(bitclk_o), .bitclk_oe_o(bitclk_oe_o), .frame_output_i(frame_w),
		.frame_output_o(frame_output_o), .frame_output_oe_o(frame_output_oe_o),
		.sample_data_out_o(sample_data_out_o));
	host_port_model host_u (.sys_clk_i(sys_clk_i), .run_i(run), .dsp_i(dsp), .data_i(sample_data_out_o),
		.bclk_o(h_bclk), .frame_o(h_frame), .done_o(done), .cap_o(cap));
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge sys_clk_i);
	endtask
	task automatic cmp(input logic [63:0] g, input logic [63:0] x);
		total_checks++;
		if (g !== x) begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		sys_clk_i = 0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	always begin
		repeat (4) @(posedge sys_clk_i);
		pll_clk_i <= ~pll_clk_i;
	end
	always begin
		repeat (6) @(posedge sys_clk_i);
		mclk_pin_i <= ~mclk_pin_i;
	end
	initial begin
		#480000;
		err_count++;
		$display("BAD %0t timeout", $time);
		close_out();
	end
	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 48'h8000_0000_0000;
		{mclk_pin_i, pll_clk_i, run, dsp} = 0;
		sample_i = 32'hB4E1_96D3;
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 0;
		@(posedge sys_clk_i);
		bus(8'h10, 0, 0);
		cmp(q, 64'h0050);
		bus(8'h18, 0, 0);
		cmp(q, 64'h0140);
		bus(8'h08, 1, 32'hFFFF_FFFF);
		bus(8'h08, 0, 0);
		cmp(q, 64'h0);
		run <= 1;
		foreach (rows[i]) begin
			bus(8'h10, 1, {23'h0, rows[i].r});
			bus(8'h10, 0, 0);
			cmp(q, {55'h0, rows[i].r});
			dsp <= (rows[i].r[4:3] == 2'b11);
			repeat (4) @(posedge done);
			for (int p = 1; p <= 64; p++)
				e[p - 1] = (p >= rows[i].s && p < rows[i].s + rows[i].wl) ? sample_i[31 - p + rows[i].s] : 1'b0;
			cmp(cap, e);
			$display("serial row %0d done", i);
		end
		run <= 0;
		foreach (mrow[i]) begin
			bus(8'h18, 1, {23'h0, mrow[i].r});
			cmp(bitclk_oe_o, 64'h1);
			repeat (2) @(posedge bitclk_o);
			// count sys edges that see bclk high, sampled before the edge updates it
			n = 0;
			@(posedge sys_clk_i);
			while (bitclk_o === 1'b1) begin
				n++;
				@(posedge sys_clk_i);
			end
			cmp(n, mrow[i].s);
			$display("master row %0d done", i);
		end
		// reset again in mid-run: registers and pin drivers must return to idle
		rst_i <= 1;
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 0;
		@(posedge sys_clk_i);
		bus(8'h18, 0, 0);
		cmp(q, 64'h0140);
		cmp(bitclk_oe_o, 64'h0);
		cmp(frame_output_oe_o, 64'h0);
		bus(8'h10, 0, 0);
		cmp(q, 64'h0050);
		$display("mid-run reset done");
		close_out();
	end
endmodule // tb_top
bind adc_audio_serial_port port_monitor mon_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .bitclk_i(bitclk_i), .bitclk_o(bitclk_o),
	.bitclk_oe_o(bitclk_oe_o), .frame_output_oe_o(frame_output_oe_o), .sample_take_o(sample_take_o),
	.sample_data_out_o(sample_data_out_o));
